// ---- rtl/scs_top.sv ----
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.svh"
module scs_top
#(
  parameter int TICK_CYCLES = `SCS_TICK_MS * `SCS_CLK_KHZ
)
(
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output var  logic [31:0]       prdata_out,
  output var  logic              pready_out,
  output var  logic              pslverr_out,
  input  wire logic              servo_on_in,
  input  wire logic              speed_select_bit0_in,
  input  wire logic              speed_select_bit1_in,
  input  wire scs_pkg::scs_adc_t analog_ref_in,
  output var  scs_pkg::scs_rpm_t speed_command_out,
  output var  scs_pkg::scs_rpm_t speed_limit_out,
  output var  logic              limit_active_out,
  output var  logic              ramp_busy_out
);
  import scs_pkg::*;

  localparam logic [`SCS_TICK_W-1:0] TICK_LAST = `SCS_TICK_W'(TICK_CYCLES - 1);

  scs_ms_t                accel_time;
  scs_ms_t                decel_time;
  scs_ms_t                scurve_time;
  scs_ms_t                analog_lowpass_time;
  scs_ms_t                max_analog_speed;
  scs_mode_t              control_mode_select;
  scs_rpm_t               preset_speed_one;
  scs_rpm_t               preset_speed_two;
  scs_rpm_t               preset_speed_three;

  logic [`SCS_TICK_W-1:0] tick_cnt;
  logic                   tick;
  logic [1:0]             sel_prev;
  logic                   servo_prev;
  logic [1:0]             sel_code;
  scs_rpm_t               preset_held;
  scs_fix_t               lp_acc;

  logic [9:0]             reg_idx;
  logic                   apb_access;
  logic                   apb_commit;
  logic                   aligned;
  logic                   hit_mode;
  logic                   hit_lowpass;
  logic                   hit_p1;
  logic                   hit_p2;
  logic                   hit_p3;
  logic                   hit_accel;
  logic                   hit_decel;
  logic                   hit_scurve;
  logic                   hit_maxspd;
  logic                   hit_status;
  logic                   hit_cmd;
  logic                   addr_ok;
  logic                   range_ok;
  logic                   time_ok;
  logic                   preset_ok;
  logic                   bad;
  logic                   wr_en;
  logic [15:0]            wdata16;
  scs_rpm_t               wdata_s;
  logic [31:0]            rd_data;

  logic [1:0]             sel_now;
  logic                   adopt;
  scs_rpm_t               preset_pick;
  logic                   zero_held;
  logic                   torque;
  logic signed [32:0]     analog_prod;
  scs_rpm_t               analog_rpm;
  scs_fix_t               analog_fix;
  scs_rpm_t               analog_cmd;
  scs_rpm_t               target;
  scs_rpm_t               ramp_speed;
  logic                   ramp_busy;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign reg_idx     = paddr_in[11:2];
  assign aligned     = (paddr_in[1:0] == 2'h0);
  assign apb_access  = psel_in & penable_in;
  assign apb_commit  = apb_access & pready_out;
  assign hit_mode    = (reg_idx == `SCS_IDX_MODE);
  assign hit_lowpass = (reg_idx == `SCS_IDX_LOWPASS);
  assign hit_p1      = (reg_idx == `SCS_IDX_PRESET1);
  assign hit_p2      = (reg_idx == `SCS_IDX_PRESET2);
  assign hit_p3      = (reg_idx == `SCS_IDX_PRESET3);
  assign hit_accel   = (reg_idx == `SCS_IDX_ACCEL);
  assign hit_decel   = (reg_idx == `SCS_IDX_DECEL);
  assign hit_scurve  = (reg_idx == `SCS_IDX_SCURVE);
  assign hit_maxspd  = (reg_idx == `SCS_IDX_MAXSPD);
  assign hit_status  = (reg_idx == `SCS_IDX_STATUS);
  assign hit_cmd     = (reg_idx == `SCS_IDX_CMD);
  assign addr_ok     = aligned & (hit_mode | hit_lowpass | hit_p1 | hit_p2 | hit_p3
                                  | hit_accel | hit_decel | hit_scurve | hit_maxspd
                                  | hit_status | hit_cmd);
  assign wdata16     = pwdata_in[15:0];
  assign wdata_s     = scs_rpm_t'(pwdata_in[15:0]);

  assign time_ok     = (wdata16 >= `SCS_TIME_MIN) && (wdata16 <= `SCS_TIME_MAX);
  assign preset_ok   = (wdata_s >= `SCS_PRESET_MIN) && (wdata_s <= `SCS_PRESET_MAX);
  assign range_ok    = (hit_accel | hit_decel) ? time_ok :
                       hit_scurve ? (wdata16 <= `SCS_SCURVE_MAX) :
                       (hit_p1 | hit_p2 | hit_p3) ? preset_ok :
                       hit_maxspd ? (wdata16 <= `SCS_MAXSPD_MAX) :
                       !(hit_status | hit_cmd);
  assign bad         = !addr_ok || (pwrite_in && !range_ok);
  assign wr_en       = apb_commit & pwrite_in & ~bad;

  assign rd_data = hit_mode    ? {30'h0, control_mode_select} :
                   hit_lowpass ? {16'h0, analog_lowpass_time} :
                   hit_p1      ? {16'h0, preset_speed_one} :
                   hit_p2      ? {16'h0, preset_speed_two} :
                   hit_p3      ? {16'h0, preset_speed_three} :
                   hit_accel   ? {16'h0, accel_time} :
                   hit_decel   ? {16'h0, decel_time} :
                   hit_scurve  ? {16'h0, scurve_time} :
                   hit_maxspd  ? {16'h0, max_analog_speed} :
                   hit_status  ? {28'h0, ramp_busy, sel_code, servo_on_in} :
                   hit_cmd     ? {16'h0, ramp_speed} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // apb response, one wait state
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= apb_access & ~pready_out;
      if (apb_access & ~pready_out)
      begin
        prdata_out  <= (pwrite_in | bad) ? 32'h0 : rd_data;
        pslverr_out <= bad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      accel_time          <= `SCS_RST_ACCEL;
      decel_time          <= `SCS_RST_DECEL;
      scurve_time         <= `SCS_RST_SCURVE;
      analog_lowpass_time <= `SCS_RST_LOWPASS;
      max_analog_speed    <= `SCS_RATED_RPM;
      control_mode_select <= SCS_MODE_SPEED;
      preset_speed_one    <= '0;
      preset_speed_two    <= '0;
      preset_speed_three  <= '0;
    end
    else if (wr_en)
    begin
      if (hit_mode)    control_mode_select <= scs_mode_t'(pwdata_in[1:0]);
      if (hit_lowpass) analog_lowpass_time <= wdata16;
      if (hit_p1)      preset_speed_one    <= wdata_s;
      if (hit_p2)      preset_speed_two    <= wdata_s;
      if (hit_p3)      preset_speed_three  <= wdata_s;
      if (hit_accel)   accel_time          <= wdata16;
      if (hit_decel)   decel_time          <= wdata16;
      if (hit_scurve)  scurve_time         <= wdata16;
      if (hit_maxspd)  max_analog_speed    <= wdata16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick
  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? '0 : tick_cnt + `SCS_TICK_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // command selection
  // closed contact reads one
  assign sel_now = {speed_select_bit1_in, speed_select_bit0_in};
  assign adopt   = servo_on_in && ((sel_now != sel_prev) || !servo_prev);
  assign preset_pick = (sel_now == `SCS_SEL_ONE) ? preset_speed_one :
                       (sel_now == `SCS_SEL_TWO) ? preset_speed_two : preset_speed_three;

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      sel_prev    <= `SCS_SEL_ANALOG;
      servo_prev  <= 1'b0;
      sel_code    <= `SCS_SEL_ANALOG;
      preset_held <= '0;
    end
    else
    begin
      sel_prev   <= sel_now;
      servo_prev <= servo_on_in;
      if (adopt)
      begin
        sel_code    <= sel_now;
        preset_held <= preset_pick;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog path
  // volts times max speed over 10 V
  assign analog_prod = 33'(analog_ref_in) * 33'(signed'({1'b0, max_analog_speed}));
  assign analog_rpm  = scs_rpm_t'(analog_prod >>> `SCS_ADC_SHIFT);
  assign analog_fix  = scs_fix_t'(analog_rpm) <<< `SCS_FRAC;
  assign analog_cmd  = (analog_lowpass_time == '0) ? analog_rpm
                                                   : lp_acc[`SCS_FRAC+15:`SCS_FRAC];

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      lp_acc <= '0;
    else if (analog_lowpass_time == '0)
      lp_acc <= analog_fix;
    else if (tick)
      lp_acc <= lp_acc + (analog_fix - lp_acc)
                / scs_fix_t'({1'b0, analog_lowpass_time} + 17'(`SCS_MS_ONE));
  end

  ////////////////////////////////////////////////////////////////////////////
  // target and ramp
  assign zero_held = (control_mode_select == SCS_MODE_SPEED_ZERO)
                   | (control_mode_select == SCS_MODE_TORQUE_ZERO);
  assign torque    = (control_mode_select == SCS_MODE_TORQUE)
                   | (control_mode_select == SCS_MODE_TORQUE_ZERO);
  assign target = !servo_on_in ? '0 :
                  (sel_code != `SCS_SEL_ANALOG) ? preset_held :
                  zero_held ? '0 : analog_cmd;

  scs_ramp u_ramp
  (
    .clock_in       (clock_in),
    .nrst_in        (nrst_in),
    .tick_in        (tick),
    .target_in      (target),
    .accel_time_in  (accel_time),
    .decel_time_in  (decel_time),
    .scurve_time_in (scurve_time),
    .speed_out      (ramp_speed),
    .busy_out       (ramp_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // torque modes give a limit
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      speed_command_out <= '0;
      speed_limit_out   <= '0;
      limit_active_out  <= 1'b0;
      ramp_busy_out     <= 1'b0;
    end
    else
    begin
      speed_command_out <= torque ? '0 : ramp_speed;
      speed_limit_out   <= torque ? ramp_speed : '0;
      limit_active_out  <= torque;
      ramp_busy_out     <= ramp_busy;
    end
  end

endmodule : scs_top
`default_nettype wire

// ---- shared/scs_consts.svh ----
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_IDX_MODE     10'h101
`define SCS_IDX_LOWPASS  10'h106
`define SCS_IDX_PRESET1  10'h109
`define SCS_IDX_PRESET2  10'h10a
`define SCS_IDX_PRESET3  10'h10b
`define SCS_IDX_ACCEL    10'h122
`define SCS_IDX_DECEL    10'h123
`define SCS_IDX_SCURVE   10'h124
`define SCS_IDX_MAXSPD   10'h128
`define SCS_IDX_STATUS   10'h140
`define SCS_IDX_CMD      10'h141

`define SCS_RST_ACCEL    16'h00c8
`define SCS_RST_DECEL    16'h00c8
`define SCS_RST_SCURVE   16'h0000
`define SCS_RST_LOWPASS  16'h0000
`define SCS_RATED_RPM    16'h0bb8

`define SCS_TIME_MIN     16'h0001
`define SCS_TIME_MAX     16'h4e20
`define SCS_SCURVE_MAX   16'h2710
`define SCS_MAXSPD_MAX   16'h1388
`define SCS_PRESET_MAX   16'sh1388
`define SCS_PRESET_MIN   16'shec78
`define SCS_MS_ONE       16'h0001

`define SCS_SEL_ANALOG   2'h0
`define SCS_SEL_ONE      2'h1
`define SCS_SEL_TWO      2'h2
`define SCS_ADC_SHIFT    15
`define SCS_FRAC         24

`define SCS_TICK_MS      1
`define SCS_CLK_KHZ      50000
`define SCS_TICK_W       16

`endif

// ---- shared/scs_pkg.sv ----
package scs_pkg;

  typedef logic signed [15:0] scs_rpm_t;
  typedef logic signed [15:0] scs_adc_t;
  typedef logic        [15:0] scs_ms_t;
  typedef logic signed [47:0] scs_fix_t;

  typedef enum logic [1:0]
  {
    SCS_MODE_SPEED       = 2'h0,
    SCS_MODE_SPEED_ZERO  = 2'h1,
    SCS_MODE_TORQUE      = 2'h2,
    SCS_MODE_TORQUE_ZERO = 2'h3
  } scs_mode_t;

  typedef enum logic [1:0]
  {
    SCS_RAMP_IDLE = 2'h1,
    SCS_RAMP_RUN  = 2'h2
  } scs_ramp_state_t;

endpackage : scs_pkg

// ---- rtl/scs_ramp.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.svh"
module scs_ramp
(
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic              tick_in,
  input  wire scs_pkg::scs_rpm_t target_in,
  input  wire scs_pkg::scs_ms_t  accel_time_in,
  input  wire scs_pkg::scs_ms_t  decel_time_in,
  input  wire scs_pkg::scs_ms_t  scurve_time_in,
  output var  scs_pkg::scs_rpm_t speed_out,
  output var  logic              busy_out
);
  import scs_pkg::*;

  localparam scs_fix_t RATED_FIX = scs_fix_t'(`SCS_RATED_RPM) <<< `SCS_FRAC;

  scs_fix_t        vel;
  scs_fix_t        acc;
  scs_ramp_state_t state;
  scs_fix_t        next_vel;
  scs_fix_t        next_acc;
  scs_ramp_state_t next_state;
  scs_fix_t        tgt_fix;
  scs_fix_t        dv;
  scs_fix_t        dv_abs;
  scs_fix_t        vel_abs;
  scs_fix_t        tgt_abs;
  scs_fix_t        acc_abs;
  scs_fix_t        amax;
  scs_fix_t        jerk;
  scs_fix_t        mag_down;
  scs_fix_t        mag_up;
  scs_fix_t        step;
  scs_ms_t         ramp_ms;
  scs_ms_t         sl_div;
  logic [95:0]     brake_lhs;
  logic [95:0]     brake_rhs;
  logic            slowing;
  logic            up;
  logic            opposing;
  logic            brake;
  logic            bypass;

  ////////////////////////////////////////////////////////////////////////////
  assign tgt_fix  = scs_fix_t'(target_in) <<< `SCS_FRAC;
  assign dv       = tgt_fix - vel;
  assign dv_abs   = dv[47] ? -dv : dv;
  assign vel_abs  = vel[47] ? -vel : vel;
  assign tgt_abs  = tgt_fix[47] ? -tgt_fix : tgt_fix;
  assign acc_abs  = acc[47] ? -acc : acc;
  assign up       = ~dv[47];
  assign slowing  = (tgt_abs < vel_abs) || ((tgt_fix[47] != vel[47]) && (vel != '0));
  assign ramp_ms  = slowing ? decel_time_in : accel_time_in;
  assign amax     = RATED_FIX / scs_fix_t'(ramp_ms);
  assign bypass   = (scurve_time_in == '0);
  assign sl_div   = bypass ? `SCS_MS_ONE : scurve_time_in;
  assign jerk     = amax / scs_fix_t'(sl_div);
  assign mag_down = (acc_abs > jerk) ? acc_abs - jerk : '0;
  assign mag_up   = (acc_abs + jerk > amax) ? amax : acc_abs + jerk;
  assign opposing = (acc != '0) && (acc[47] != dv[47]);
  assign brake_lhs = 96'(acc_abs) * 96'(acc_abs);
  assign brake_rhs = (96'(jerk) * 96'(dv_abs)) << 1;
  assign brake    = brake_lhs >= brake_rhs;

  ////////////////////////////////////////////////////////////////////////////
  // jerk-limited three segments
  always_comb
  begin
    next_vel = vel;
    next_acc = acc;
    step     = vel;
    if (bypass)
    begin
      next_vel = tgt_fix;
      next_acc = '0;
    end
    else if (tick_in && ((dv != '0) || (acc != '0)))
    begin
      if (opposing || brake)
        next_acc = acc[47] ? -mag_down : mag_down;
      else
        next_acc = up ? mag_up : -mag_up;
      step = vel + next_acc;
      if (!opposing && (up ? (step >= tgt_fix) : (step <= tgt_fix)))
      begin
        next_vel = tgt_fix;
        next_acc = '0;
      end
      else
        next_vel = step;
    end
  end

  always_comb
  begin
    case (state)
      SCS_RAMP_IDLE: next_state = (next_vel != tgt_fix) ? SCS_RAMP_RUN : SCS_RAMP_IDLE;
      SCS_RAMP_RUN:
        next_state = ((next_vel == tgt_fix) && (next_acc == '0)) ? SCS_RAMP_IDLE
                                                                 : SCS_RAMP_RUN;
      default:       next_state = SCS_RAMP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state carries over on new target
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      vel       <= '0;
      acc       <= '0;
      state     <= SCS_RAMP_IDLE;
      speed_out <= '0;
      busy_out  <= 1'b0;
    end
    else
    begin
      vel       <= next_vel;
      acc       <= next_acc;
      state     <= next_state;
      speed_out <= next_vel[`SCS_FRAC+15:`SCS_FRAC];
      busy_out  <= (next_state == SCS_RAMP_RUN);
    end
  end

endmodule : scs_ramp
`default_nettype wire

// ---- tb/scs_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.svh"
module scs_monitor
  import scs_pkg::*;
#(
  parameter int TICK_CYCLES = 50
)
(
  input wire logic              clock_in,
  input wire logic              nrst_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [11:0]       paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              servo_on_in,
  input wire logic              speed_select_bit0_in,
  input wire logic              speed_select_bit1_in,
  input wire scs_pkg::scs_adc_t analog_ref_in,
  input wire scs_pkg::scs_rpm_t speed_command_out,
  input wire scs_pkg::scs_rpm_t speed_limit_out,
  input wire logic              limit_active_out,
  input wire logic              ramp_busy_out
);
  localparam logic [11:0] A_MOD = {`SCS_IDX_MODE, 2'b00};
  localparam logic [11:0] A_ACC = {`SCS_IDX_ACCEL, 2'b00};
  localparam logic [11:0] A_DEC = {`SCS_IDX_DECEL, 2'b00};
  localparam logic [11:0] A_SCV = {`SCS_IDX_SCURVE, 2'b00};
  localparam logic [11:0] A_CMD = {`SCS_IDX_CMD, 2'b00};
  wire wr = psel_in && penable_in && pready_out && pwrite_in;
  wire [15:0] wd = pwdata_in[15:0];
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////
  AST_RDY_WAIT:
    assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
    else $error("ready not after one wait state");
  AST_RDY_PULSE:
    assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
  AST_RD_UPPER:
    assert property (pready_out |-> prdata_out[31:16] == 16'h0000) else $error("upper data set");
  AST_TORQ_CMD:
    assert property (limit_active_out |-> speed_command_out == 16'sh0000)
    else $error("command not zero in torque mode");
  AST_SPD_LIM:
    assert property (!limit_active_out |-> speed_limit_out == 16'sh0000)
    else $error("limit not zero in speed mode");
  AST_MODE_ON:
    assert property (wr && paddr_in == A_MOD && pwdata_in[1] |-> ##2 limit_active_out)
    else $error("torque mode not flagged");
  AST_MODE_OFF:
    assert property (wr && paddr_in == A_MOD && !pwdata_in[1] |-> ##2 !limit_active_out)
    else $error("speed mode flagged as limit");
  AST_TIME_RANGE:
    assert property (wr && (paddr_in == A_ACC || paddr_in == A_DEC) &&
                     (wd == 16'h0000 || wd > `SCS_TIME_MAX) |-> pslverr_out)
    else $error("bad ramp time accepted");
  AST_SCV_RANGE:
    assert property (wr && paddr_in == A_SCV && wd > `SCS_SCURVE_MAX |-> pslverr_out)
    else $error("bad s-curve time accepted");
  AST_RO_ERR:
    assert property (wr && paddr_in == A_CMD |-> pslverr_out) else $error("read-only written");
endmodule : scs_monitor
bind scs_top scs_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_scs_monitor
(
  .clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .servo_on_in(servo_on_in), .speed_select_bit0_in(speed_select_bit0_in),
  .speed_select_bit1_in(speed_select_bit1_in), .analog_ref_in(analog_ref_in),
  .speed_command_out(speed_command_out), .speed_limit_out(speed_limit_out),
  .limit_active_out(limit_active_out), .ramp_busy_out(ramp_busy_out)
);
`default_nettype wire

// ---- tb/scs_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module scs_host
(
  input  wire logic              clock_in,
  input  wire logic              servo_req_in,
  input  wire logic [1:0]        code_req_in,
  input  wire scs_pkg::scs_adc_t volt_req_in,
  output var  logic              servo_on_out,
  output var  logic              select_bit0_out,
  output var  logic              select_bit1_out,
  output var  scs_pkg::scs_adc_t analog_out
);
  import scs_pkg::*;
  always @(posedge clock_in)
  begin
    servo_on_out <= servo_req_in;
    select_bit0_out <= code_req_in[0];
    select_bit1_out <= code_req_in[1];
    analog_out <= volt_req_in;
  end
endmodule : scs_host
`default_nettype wire

// ---- tb/speed_command_select_scurve_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.svh"
module speed_command_select_scurve_bench;
  import scs_pkg::*;
  localparam int TK = 4;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        srv = 1'b0;
  logic [1:0]  code = 2'h0;
  scs_adc_t    volt = 16'sh0000;
  logic        son;
  logic        b0;
  logic        b1;
  scs_adc_t    aref;
  scs_rpm_t    cmd;
  scs_rpm_t    lim;
  logic        lact;
  logic        busy;
  logic [31:0] r;
  logic        e;
  scs_rpm_t    pr [3];
  logic [15:0] m;
  scs_adc_t    av;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  scs_host i_scs_host
  (
    .clock_in(clk), .servo_req_in(srv), .code_req_in(code), .volt_req_in(volt),
    .servo_on_out(son), .select_bit0_out(b0), .select_bit1_out(b1), .analog_out(aref)
  );
  scs_top #(.TICK_CYCLES(TK)) i_scs_top
  (
    .clock_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .servo_on_in(son), .speed_select_bit0_in(b0),
    .speed_select_bit1_in(b1), .analog_ref_in(aref), .speed_command_out(cmd),
    .speed_limit_out(lim), .limit_active_out(lact), .ramp_busy_out(busy)
  );
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {ix, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (n == 20)
      n_fail++;
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] ix, input logic [31:0] x, input logic xe);
    apb(1'b0, ix, 32'h0);
    chk(r, x);
    chk(e, xe);
  endtask : rd
  task automatic wr(input logic [9:0] ix, input logic [15:0] d, input logic xe);
    apb(1'b1, ix, {16'h0000, d});
    chk(e, xe);
  endtask : wr
  task automatic host(input logic s, input logic [1:0] c, input scs_adc_t v);
    @(posedge clk);
    srv <= s;
    code <= c;
    volt <= v;
  endtask : host
  task automatic sett(input logic l, input scs_rpm_t x);
    int n;
    n = 0;
    while ((l ? lim : cmd) !== x && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk(l ? lim : cmd, x);
  endtask : sett
  task automatic ramp(input scs_rpm_t x, input int mx, input int lo, input int hi);
    int n;
    int d;
    int dm;
    int f;
    logic bs;
    scs_rpm_t pv;
    n = 0;
    dm = 0;
    f = 0;
    bs = 1'b0;
    pv = cmd;
    while (cmd !== x && n < 400)
    begin
      @(negedge clk);
      d = int'(cmd) - int'(pv);
      d = (d < 0) ? -d : d;
      f = (f == 0) ? d : f;
      dm = (d > dm) ? d : dm;
      bs = bs | (busy === 1'b1);
      pv = cmd;
      n++;
    end
    chk(dm <= mx + 1, 1'b1);
    chk(lo == 0 || f <= mx / 2 + 1, 1'b1);
    chk(n >= lo && n <= hi && cmd === x, 1'b1);
    chk(bs, lo != 0);
    chk(busy, 1'b0);
  endtask : ramp
  function automatic scs_rpm_t f_an(input scs_adc_t v, input logic [15:0] mx);
    logic signed [31:0] p;
    p = v * $signed({1'b0, mx});
    return p[30:15];
  endfunction : f_an
  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h32090a53));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(`SCS_IDX_ACCEL, 32'hc8, 1'b0);
    rd(`SCS_IDX_DECEL, 32'hc8, 1'b0);
    rd(`SCS_IDX_SCURVE, 32'h0, 1'b0);
    wr(`SCS_IDX_ACCEL, 16'h0000, 1'b1);
    wr(`SCS_IDX_ACCEL, 16'h4e21, 1'b1);
    wr(`SCS_IDX_ACCEL, `SCS_TIME_MAX, 1'b0);
    rd(`SCS_IDX_ACCEL, {16'h0, `SCS_TIME_MAX}, 1'b0);
    wr(`SCS_IDX_DECEL, 16'h4e21, 1'b1);
    wr(`SCS_IDX_DECEL, 16'h0001, 1'b0);
    rd(`SCS_IDX_DECEL, 32'h1, 1'b0);
    wr(`SCS_IDX_SCURVE, 16'h2711, 1'b1);
    wr(`SCS_IDX_SCURVE, `SCS_SCURVE_MAX, 1'b0);
    wr(`SCS_IDX_SCURVE, 16'h0000, 1'b0);
    wr(`SCS_IDX_CMD, 16'h0001, 1'b1);
    rd(10'h3ff, 32'h0, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      pr[i] = 16'($urandom_range(10000)) - 16'sd5000;
      wr(`SCS_IDX_PRESET1 + 10'(i), pr[i], 1'b0);
    end
    for (int c = 1; c < 4; c++)
    begin
      host(1'b1, 2'(c), volt);
      sett(1'b0, pr[c-1]);
    end
    rd(`SCS_IDX_STATUS, 32'h7, 1'b0);
    wr(`SCS_IDX_PRESET3, pr[0], 1'b0);
    repeat (3 * TK) @(negedge clk);
    chk(cmd, pr[2]);
    host(1'b1, 2'h1, volt);
    host(1'b1, 2'h3, volt);
    sett(1'b0, pr[0]);
    host(1'b0, 2'h2, volt);
    sett(1'b0, 16'sh0000);
    host(1'b1, 2'h2, volt);
    sett(1'b0, pr[1]);
    for (int i = 0; i < 4; i++)
    begin
      m = (i < 2) ? 16'($urandom_range(5000)) : `SCS_MAXSPD_MAX;
      av = (i < 2) ? scs_adc_t'($urandom) : (i == 2) ? 16'sh7fff : 16'sh8000;
      wr(`SCS_IDX_MAXSPD, m, 1'b0);
      host(1'b1, 2'h0, av);
      sett(1'b0, f_an(av, m));
    end
    wr(`SCS_IDX_MODE, 16'h0001, 1'b0);
    sett(1'b0, 16'sh0000);
    wr(`SCS_IDX_MODE, 16'h0003, 1'b0);
    host(1'b1, 2'h2, volt);
    sett(1'b1, pr[1]);
    chk(cmd, 32'h0);
    host(1'b1, 2'h0, volt);
    sett(1'b1, 16'sh0000);
    wr(`SCS_IDX_MODE, 16'h0002, 1'b0);
    sett(1'b1, f_an(volt, m));
    wr(`SCS_IDX_MODE, 16'h0000, 1'b0);
    wr(`SCS_IDX_PRESET1, 16'd3000, 1'b0);
    wr(`SCS_IDX_PRESET2, 16'd1500, 1'b0);
    wr(`SCS_IDX_PRESET3, 16'd0, 1'b0);
    host(1'b1, 2'h3, volt);
    sett(1'b0, 16'sh0000);
    wr(`SCS_IDX_ACCEL, 16'd10, 1'b0);
    wr(`SCS_IDX_DECEL, 16'd20, 1'b0);
    wr(`SCS_IDX_SCURVE, 16'd2, 1'b0);
    host(1'b1, 2'h1, volt);
    ramp(16'sd3000, 300, 11 * TK, 15 * TK + 4);
    host(1'b1, 2'h2, volt);
    ramp(16'sd1500, 150, 11 * TK, 15 * TK + 4);
    host(1'b1, 2'h0, 16'sh4ccd);
    ramp(16'sd3000, 300, 6 * TK, 9 * TK + 4);
    host(1'b1, 2'h3, volt);
    repeat (20) @(posedge clk);
    host(1'b1, 2'h1, volt);
    ramp(16'sd3000, 300, 1, 100 * TK);
    wr(`SCS_IDX_SCURVE, 16'h0000, 1'b0);
    wr(`SCS_IDX_LOWPASS, 16'h0001, 1'b0);
    host(1'b1, 2'h0, 16'sh0000);
    ramp(16'sh0000, 1500, 0, 13 * TK + 4);
    summarize();
  end
endmodule : speed_command_select_scurve_bench
`default_nettype wire
